// ===== hdl/ptg_pkg.sv
// Behaviour
// [RQ1] prescale codes 0..6 divide input clock by 1..64; code 7 reserved; resets to 1
// [RQ2] software changes prescale only while module enable is low
// [RQ3] software loads master period only within 0x0010..0xFFF8
// [RQ4] master period holds 16-bit period; bits 15..3 reset one, 2..0 zero
// [RQ5] special event compare keeps bits 15..3; bits 2..0 read zero
// [RQ6] software keeps master duty between 0x0008 and period minus 0x0008
// [RQ7] duty resolution may coarsen to 3 counts within 40 ns of edges
// [RQ8] fault, current-limit, trigger pending flags sit in control bits 15, 14, 13
// [RQ9] writing an enable bit zero disables that source and clears its flag; an event in the cycle of that write still sets the flag for one cycle
// [RQ10] each enabled source raises its interrupt request on its event
// [RQ11] service software clears generator flag and system interrupt flag
// [RQ12] independent time base set: own phase period; else master period
// [RQ13] master duty select set: master duty; else own primary and secondary duty
// [RQ14] dead-time field: 00 positive, 01 negative, 10 none, 11 reserved
// [RQ15] center-aligned enable acts only with independent time base set
// [RQ16] external reset bit with independent base: current-limit source restarts base
// [RQ17] external period reset needs current-limit mode zero and independent base; code gates on enable bit and independent base only
// [RQ18] immediate update set: duty applies at once; else at cycle boundary
// [RQ19] software changes base, duty select, center bits only while disabled
// [RQ20] unimplemented prescale bits 15..3 and control bits 5..3 read zero
// [RQ21] module enable runs the module when set and stops it when cleared
// [RQ22] master counter counts prescaled ticks zero to period, then restarts
package ptg_pkg;
  localparam logic [7:0] OFS_TIMEBASE_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESCALE = 8'h04;
  localparam logic [7:0] OFS_MASTER_PERIOD = 8'h08;
  localparam logic [7:0] OFS_SPECIAL_CMP = 8'h0C;
  localparam logic [7:0] OFS_MASTER_DUTY = 8'h10;
  localparam logic [7:0] OFS_GEN_CTRL = 8'h14;

  localparam int BIT_MODULE_ENABLE = 15;
  localparam int BIT_ITB = 9;
  localparam int BIT_MASTER_DUTY_SELECT = 8;
  localparam int BIT_DTC_LO = 6;
  localparam int BIT_CAM = 2;
  localparam int BIT_EXTERNAL_PERIOD_RESET_ENABLE = 1;
  localparam int BIT_IUE = 0;
  localparam int BIT_IEN_LO = 10;
  localparam int BIT_STAT_LO = 13;

  localparam logic [15:0] PERIOD_RST = 16'hFFF8;
  localparam logic [15:0] SPECIAL_CMP_MASK = 16'hFFF8;
  localparam logic [15:0] GEN_CTRL_RW_MASK = 16'h1FC7;
  localparam logic [2:0] PRESCALE_RESERVED = 3'h7;
  localparam logic [2:0] PRESCALE_MAX = 3'h6;

  localparam logic [1:0] DTC_POSITIVE = 2'h0;
  localparam logic [1:0] DTC_NEGATIVE = 2'h1;
  localparam logic [1:0] DTC_NONE = 2'h2;
  localparam logic [1:0] DTC_RESERVED = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLOCK_MHZ = 250;
  localparam int RES_BAND_NS = 40;
  localparam logic [15:0] RES_BAND_COUNTS = 16'(RES_BAND_NS * CLOCK_MHZ / 1000);
  localparam logic [15:0] DUTY_COARSE_STEP = 16'h0003;

  typedef enum logic {TB_UP, TB_DOWN} ptg_dir_type;
endpackage

// ===== hdl/ptg_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module ptg_prescaler #(
  parameter int DIV_W = 6
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_run,
  input wire logic [2:0] i_select,
  output logic o_tick
);
  import ptg_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } ptg_presc_state_type;

  ptg_presc_state_type st_q, st_d;
  logic [DIV_W-1:0] limit;

  generate
    if (DIV_W < int'(PRESCALE_MAX)) begin : g_bad_width
      $error("ptg_prescaler: DIV_W too small for divide by 64");
    end
  endgenerate

  always_comb begin
    limit = DIV_W'(({{DIV_W{1'b0}}, 1'b1} << i_select) - 1'b1);
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!i_run || i_select == PRESCALE_RESERVED) begin // RQ1
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit) begin // RQ1
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_div2_held;
    (i_run && i_select == 3'h1) [*2];
  endsequence

  a_div_one_rate: assert property ((i_run && i_select == 3'h0) |=> o_tick) // RQ1
    else $error("divide by one missed a tick");
  a_reserved_stops: assert property ((!i_run || i_select == 3'h7) |=> !o_tick) // RQ1
    else $error("tick while stopped or reserved");
  a_div_two_gap: assert property ((o_tick && i_run && i_select == 3'h1) |=> !o_tick) // RQ1
    else $error("divide by two ticked twice in a row");
  a_div_two_next: assert property ((o_tick ##0 s_div2_held) |=> o_tick) // RQ1
    else $error("divide by two tick late");
endmodule
`default_nettype wire

// ===== hdl/ptg_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module ptg_timebase #(
  parameter int CNT_W = 16
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [CNT_W-1:0] i_period,
  input wire logic i_center,
  input wire logic i_restart,
  output logic [CNT_W-1:0] o_count,
  output logic o_boundary
);
  import ptg_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic boundary;
    ptg_dir_type dir;
  } ptg_tb_state_type;

  ptg_tb_state_type st_q, st_d;

  generate
    if (CNT_W < 4) begin : g_bad_width
      $error("ptg_timebase: CNT_W below 4");
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.boundary = 1'b0;
    if (!i_run) begin // RQ21
      st_d.count = '0;
      st_d.dir = TB_UP;
    end else if (i_restart) begin // RQ16
      st_d.count = '0;
      st_d.dir = TB_UP;
      st_d.boundary = 1'b1;
    end else if (i_tick) begin
      case (st_q.dir)
        TB_UP: begin
          if (st_q.count >= i_period) begin
            if (i_center) begin // RQ15
              st_d.dir = TB_DOWN;
              st_d.count = st_q.count - 1'b1;
            end else begin // RQ22
              st_d.count = '0;
              st_d.boundary = 1'b1;
            end
          end else begin
            st_d.count = st_q.count + 1'b1; // RQ22
          end
        end
        TB_DOWN: begin
          if (st_q.count <= CNT_W'(1)) begin
            st_d.count = '0;
            st_d.dir = TB_UP;
            st_d.boundary = 1'b1;
          end else begin
            st_d.count = st_q.count - 1'b1;
          end
        end
        default: begin
          st_d.count = '0;
          st_d.dir = TB_UP;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_count = st_q.count;
  assign o_boundary = st_q.boundary;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_wrap_to_zero: assert property ((i_run && !i_restart && i_tick && !i_center && st_q.dir == TB_UP // RQ22
      && o_count >= i_period) |=> (o_count == '0 && o_boundary))
    else $error("counter did not restart at period");
  a_count_step: assert property ((i_run && !i_restart && i_tick && st_q.dir == TB_UP // RQ22
      && o_count < i_period) |=> o_count == $past(o_count) + 1'b1)
    else $error("counter did not advance by one");
  a_ext_restart: assert property ((i_run && i_restart) |=> (o_count == '0 && o_boundary)) // RQ16
    else $error("external restart ignored");
  a_stopped_clear: assert property (!i_run |=> (o_count == '0 && !o_boundary)) // RQ21
    else $error("counter moved while disabled");
  a_hold_no_tick: assert property ((i_run && !i_restart && !i_tick) |=> $stable(o_count)) // RQ22
    else $error("counter moved without a tick");
endmodule
`default_nettype wire

// ===== hdl/ptg_top.sv
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ptg_top #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_fault_event,
  input wire logic i_current_limit_event,
  input wire logic i_trigger_event,
  input wire logic [CNT_W-1:0] i_primary_phase_shift,
  input wire logic [CNT_W-1:0] i_primary_duty_cycle,
  input wire logic [CNT_W-1:0] i_secondary_duty_cycle,
  output logic [2:0] o_irq_request,
  output logic o_pwm_primary,
  output logic o_pwm_secondary,
  output logic [CNT_W-1:0] o_timebase_count,
  output logic o_cycle_boundary,
  output logic o_special_event,
  output logic [1:0] o_dead_time_mode,
  output logic o_center_aligned
);
  import ptg_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic module_enable;
    logic [2:0] prescale;
    logic [15:0] period;
    logic [15:0] special_cmp;
    logic [15:0] master_duty;
    logic [15:0] genctl;
    logic [2:0] pending;
    logic [CNT_W-1:0] act_pri;
    logic [CNT_W-1:0] act_sec;
    logic pwm_pri;
    logic pwm_sec;
    logic [CNT_W-1:0] count_out;
    logic boundary_out;
    logic special_out;
    logic [1:0] dtc_out;
    logic center_out;
  } ptg_top_state_type;

  ptg_top_state_type st_q, st_d;
  logic tick, mst_boundary, gen_boundary, gen_restart, wr_fire, independent_timebase_sel, sel_boundary;
  logic [CNT_W-1:0] mst_count, gen_count, sel_count, sel_period, src_pri, src_sec;
  logic [2:0] events;

  generate
    if (ADDR_W < 5 || CNT_W != 16) begin : g_bad_param
      $error("ptg_top: ADDR_W must be 5 or more and CNT_W 16");
    end
  endgenerate

  function automatic logic at(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    at = {addr[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data, input logic [1:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // near either edge of the period the edge placement loses its finest steps
  function automatic logic [15:0] coarse(input logic [15:0] duty, input logic [15:0] per);
    logic [15:0] rem;
    rem = duty % DUTY_COARSE_STEP;
    if (duty < RES_BAND_COUNTS || {1'b0, duty} + {1'b0, RES_BAND_COUNTS} > {1'b0, per}) begin // RQ7
      coarse = duty - rem;
    end else begin
      coarse = duty;
    end
  endfunction

  ptg_prescaler #(
    .DIV_W(6)
  ) u_prescaler (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(st_q.module_enable),
    .i_select(st_q.prescale),
    .o_tick(tick)
  );

  ptg_timebase #(
    .CNT_W(CNT_W)
  ) u_master_tb (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(st_q.module_enable),
    .i_tick(tick),
    .i_period(st_q.period),
    .i_center(1'b0),
    .i_restart(1'b0),
    .o_count(mst_count),
    .o_boundary(mst_boundary)
  );

  ptg_timebase #(
    .CNT_W(CNT_W)
  ) u_gen_tb (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(st_q.module_enable && independent_timebase_sel),
    .i_tick(tick),
    .i_period(i_primary_phase_shift),
    .i_center(st_q.genctl[BIT_CAM]), // RQ15
    .i_restart(gen_restart),
    .o_count(gen_count),
    .o_boundary(gen_boundary)
  );

  assign independent_timebase_sel = st_q.genctl[BIT_ITB];
  assign gen_restart = st_q.genctl[BIT_EXTERNAL_PERIOD_RESET_ENABLE] && independent_timebase_sel && i_current_limit_event; // RQ16
  assign sel_count = independent_timebase_sel ? gen_count : mst_count; // RQ12
  assign sel_boundary = independent_timebase_sel ? gen_boundary : mst_boundary; // RQ12
  assign sel_period = independent_timebase_sel ? i_primary_phase_shift : st_q.period; // RQ12
  assign src_pri = st_q.genctl[BIT_MASTER_DUTY_SELECT] ? st_q.master_duty : i_primary_duty_cycle; // RQ13
  assign src_sec = st_q.genctl[BIT_MASTER_DUTY_SELECT] ? st_q.master_duty : i_secondary_duty_cycle; // RQ13
  assign events = {i_fault_event, i_current_limit_event, i_trigger_event};
  assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;

  always_comb begin
    st_d = st_q;
    if (i_s_axi_awvalid && st_q.awready) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && st_q.wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = i_s_axi_wdata[15:0];
      st_d.wstrb = i_s_axi_wstrb[1:0];
    end
    if (st_q.bvalid && i_s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      if (at(st_q.awaddr, OFS_TIMEBASE_CTRL)) begin
        if (st_q.wstrb[1]) begin
          st_d.module_enable = st_q.wdata[BIT_MODULE_ENABLE]; // RQ21
        end
      end else if (at(st_q.awaddr, OFS_PRESCALE)) begin
        if (st_q.wstrb[0]) begin
          st_d.prescale = st_q.wdata[2:0]; // RQ1
        end
      end else if (at(st_q.awaddr, OFS_MASTER_PERIOD)) begin
        st_d.period = merge(st_q.period, st_q.wdata, st_q.wstrb); // RQ4
      end else if (at(st_q.awaddr, OFS_SPECIAL_CMP)) begin
        st_d.special_cmp = merge(st_q.special_cmp, st_q.wdata, st_q.wstrb) & SPECIAL_CMP_MASK; // RQ5
      end else if (at(st_q.awaddr, OFS_MASTER_DUTY)) begin
        st_d.master_duty = merge(st_q.master_duty, st_q.wdata, st_q.wstrb);
      end else if (at(st_q.awaddr, OFS_GEN_CTRL)) begin
        st_d.genctl = merge(st_q.genctl, st_q.wdata, st_q.wstrb) & GEN_CTRL_RW_MASK; // RQ20
      end else begin
        st_d.bresp = RESP_SLVERR;
      end
    end
    // an event in the cycle of a disabling write still lands
    for (int i = 0; i < 3; i++) begin
      st_d.pending[i] = (st_q.pending[i] && st_d.genctl[BIT_IEN_LO + i]) // RQ9
          || (events[i] && st_q.genctl[BIT_IEN_LO + i]); // RQ8 RQ10
    end
    if (st_q.rvalid && i_s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      st_d.rdata = '0;
      if (at(i_s_axi_araddr, OFS_TIMEBASE_CTRL)) begin
        st_d.rdata[BIT_MODULE_ENABLE] = st_q.module_enable;
      end else if (at(i_s_axi_araddr, OFS_PRESCALE)) begin
        st_d.rdata[2:0] = st_q.prescale; // RQ20
      end else if (at(i_s_axi_araddr, OFS_MASTER_PERIOD)) begin
        st_d.rdata[15:0] = st_q.period;
      end else if (at(i_s_axi_araddr, OFS_SPECIAL_CMP)) begin
        st_d.rdata[15:0] = st_q.special_cmp; // RQ5
      end else if (at(i_s_axi_araddr, OFS_MASTER_DUTY)) begin
        st_d.rdata[15:0] = st_q.master_duty;
      end else if (at(i_s_axi_araddr, OFS_GEN_CTRL)) begin
        st_d.rdata[15:0] = st_q.genctl | {st_q.pending, 13'h0000}; // RQ8
      end else begin
        st_d.rresp = RESP_SLVERR;
      end
    end
    st_d.awready = !st_d.aw_got && !st_d.bvalid;
    st_d.wready = !st_d.w_got && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
    // staged duty values move only at the boundary unless updates are immediate
    if (st_q.genctl[BIT_IUE] || sel_boundary) begin // RQ18
      st_d.act_pri = src_pri;
      st_d.act_sec = src_sec;
    end
    st_d.pwm_pri = st_q.module_enable && sel_count < coarse(st_q.act_pri, sel_period);
    st_d.pwm_sec = st_q.module_enable && sel_count < coarse(st_q.act_sec, sel_period);
    st_d.count_out = sel_count;
    st_d.boundary_out = sel_boundary;
    st_d.special_out = st_q.module_enable && tick && mst_count == st_q.special_cmp;
    // reserved dead-time code is treated as no dead time
    st_d.dtc_out = st_q.genctl[BIT_DTC_LO +: 2] == DTC_RESERVED ? DTC_NONE : st_q.genctl[BIT_DTC_LO +: 2]; // RQ14
    st_d.center_out = st_q.genctl[BIT_CAM] && independent_timebase_sel; // RQ15
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_q <= '0;
      st_q.period <= PERIOD_RST; // RQ4
    end else begin
      st_q <= st_d;
    end
  end

  assign o_s_axi_awready = st_q.awready;
  assign o_s_axi_wready = st_q.wready;
  assign o_s_axi_bvalid = st_q.bvalid;
  assign o_s_axi_bresp = st_q.bresp;
  assign o_s_axi_arready = st_q.arready;
  assign o_s_axi_rvalid = st_q.rvalid;
  assign o_s_axi_rdata = st_q.rdata;
  assign o_s_axi_rresp = st_q.rresp;
  assign o_irq_request = st_q.pending;
  assign o_pwm_primary = st_q.pwm_pri;
  assign o_pwm_secondary = st_q.pwm_sec;
  assign o_timebase_count = st_q.count_out;
  assign o_cycle_boundary = st_q.boundary_out;
  assign o_special_event = st_q.special_out;
  assign o_dead_time_mode = st_q.dtc_out;
  assign o_center_aligned = st_q.center_out;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_trig_flag_set: assert property ((i_trigger_event && st_q.genctl[10]) |=> o_irq_request[0]) // RQ10
    else $error("trigger event did not pend");
  a_fault_flag_set: assert property ((i_fault_event && st_q.genctl[12]) |=> o_irq_request[2]) // RQ8
    else $error("fault event did not pend");
  a_flag_disabled: assert property ((!st_q.genctl[11] && !$past(st_q.genctl[11])) |-> !o_irq_request[1]) // RQ9
    else $error("current-limit flag pending while disabled");
  a_special_low: assert property (st_q.special_cmp[2:0] == 3'h0) // RQ5
    else $error("special compare low bits not zero");
  a_iue_immediate: assert property (st_q.genctl[0] |=> st_q.act_pri == $past(src_pri)) // RQ18
    else $error("immediate update not applied");
  a_sync_hold: assert property ((!st_q.genctl[0] && !sel_boundary) |=> $stable(st_q.act_pri)) // RQ18
    else $error("duty changed between boundaries");
  a_master_duty_select_select: assert property ((st_q.genctl[8] && st_q.genctl[0]) |=> st_q.act_sec == $past(st_q.master_duty)) // RQ13
    else $error("master duty not selected");
  a_center_gate: assert property (!st_q.genctl[9] |=> !o_center_aligned) // RQ15
    else $error("center mode without independent base");
  a_bresp_hold: assert property ((o_s_axi_bvalid && !i_s_axi_bready) |=> (o_s_axi_bvalid && $stable(o_s_axi_bresp)))
    else $error("write response dropped before taken");

  sequence s_aw_w_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_bvalid_next;
    ##1 !o_s_axi_bvalid ##1 o_s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_aw_w_taken |-> s_bvalid_next)
    else $error("write response not two edges after both halves");
  a_read_answer: assert property ((i_s_axi_arvalid && o_s_axi_arready) |=> (o_s_axi_rvalid && !o_s_axi_arready))
    else $error("read answer late or address still open");
  a_rdata_hold: assert property ((o_s_axi_rvalid && !i_s_axi_rready) |=> (o_s_axi_rvalid && $stable(o_s_axi_rdata)))
    else $error("read data dropped before taken");
  a_pwm_off_stopped: assert property (!st_q.module_enable |=> (!o_pwm_primary && !o_pwm_secondary)) // RQ21
    else $error("pwm output active while disabled");
  a_dtc_reserved: assert property ((st_q.genctl[7:6] == DTC_RESERVED) |=> o_dead_time_mode == DTC_NONE) // RQ14
    else $error("reserved dead-time code not shown as none");
endmodule
`default_nettype wire

// ===== testbench/ptg_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module ptg_power_stage (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_gate_hi,
  input wire logic i_gate_lo,
  input wire logic i_boundary,
  output logic [15:0] o_hi_on,
  output logic [15:0] o_lo_on
);
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  // conduction is totalled per pwm cycle, so any fixed output lag cancels out
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      o_hi_on <= 16'h0000;
      o_lo_on <= 16'h0000;
    end else if (i_boundary) begin
      o_hi_on <= hi_q;
      o_lo_on <= lo_q;
      hi_q <= 16'(i_gate_hi);
      lo_q <= 16'(i_gate_lo);
    end else begin
      hi_q <= hi_q + 16'(i_gate_hi);
      lo_q <= lo_q + 16'(i_gate_lo);
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ptg_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic fev = 1'b0, cev = 1'b0, tev = 1'b0;
  logic [15:0] ph = 16'h0020, pd = 16'h000C, sd = 16'h000E;
  wire logic awr, wrd, bv, arr, rv, pp, ps, cb, ca, sev;
  wire logic [1:0] br, rr, dtm;
  wire logic [31:0] rd;
  wire logic [2:0] irq;
  wire logic [15:0] cnt, hon, lon;
  logic [1:0] lastb;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int nsev = 0;
  int len;

  ptg_top dut_u (.i_clock(clk), .i_nrst(nrst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rry), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .i_fault_event(fev),
    .i_current_limit_event(cev), .i_trigger_event(tev), .i_primary_phase_shift(ph),
    .i_primary_duty_cycle(pd), .i_secondary_duty_cycle(sd), .o_irq_request(irq),
    .o_pwm_primary(pp), .o_pwm_secondary(ps), .o_timebase_count(cnt), .o_cycle_boundary(cb),
    .o_special_event(sev), .o_dead_time_mode(dtm), .o_center_aligned(ca));

  ptg_power_stage stage_u (.i_clock(clk), .i_nrst(nrst), .i_gate_hi(pp), .i_gate_lo(ps),
    .i_boundary(cb), .o_hi_on(hon), .o_lo_on(lon));

  always #2 clk = ~clk;

  task automatic end_of_test;
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (sev === 1'b1) nsev++;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    lastb = br;
    bry <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      d = rd;
      r = rr;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    chk(nm, e, d);
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask

  // first boundary wait is partial; the last one spans a whole cycle
  task automatic bnd(input int n, output int l);
    repeat (n) begin
      l = 0;
      do begin
        @(posedge clk);
        l++;
      end while (cb !== 1'b1);
    end
  endtask

  task automatic pulse_all;
    @(posedge clk);
    fev <= 1'b1;
    cev <= 1'b1;
    tev <= 1'b1;
    @(posedge clk);
    fev <= 1'b0;
    cev <= 1'b0;
    tev <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset;
    rdc(OFS_TIMEBASE_CTRL, 32'h0, RESP_OKAY, "timebase ctrl");
    rdc(OFS_PRESCALE, 32'h0, RESP_OKAY, "prescale");
    rdc(OFS_MASTER_PERIOD, 32'h0000FFF8, RESP_OKAY, "period");
    rdc(OFS_SPECIAL_CMP, 32'h0, RESP_OKAY, "special compare");
    rdc(OFS_MASTER_DUTY, 32'h0, RESP_OKAY, "master duty");
    rdc(OFS_GEN_CTRL, 32'h0, RESP_OKAY, "gen ctrl");
    rdc(8'h18, 32'h0, RESP_SLVERR, "unmapped read");
    wr(8'h18, 32'hFFFF);
    chk("unmapped write response", {30'h0, RESP_SLVERR}, {30'h0, lastb});
  endtask

  task automatic t_bits;
    wr(OFS_PRESCALE, 32'hFFFF);
    rdc(OFS_PRESCALE, 32'h7, RESP_OKAY, "prescale bits");
    wr(OFS_PRESCALE, 32'h0);
    wr(OFS_SPECIAL_CMP, 32'hFFFF);
    rdc(OFS_SPECIAL_CMP, 32'hFFF8, RESP_OKAY, "special compare bits");
    wr(OFS_GEN_CTRL, 32'hFFFF);
    rdc(OFS_GEN_CTRL, 32'h1FC7, RESP_OKAY, "gen ctrl bits");
    wr(OFS_GEN_CTRL, 32'h0);
    wr(OFS_MASTER_PERIOD, 32'h0010);
    rdc(OFS_MASTER_PERIOD, 32'h0010, RESP_OKAY, "period write");
  endtask

  task automatic t_irq;
    pulse_all();
    chk("irq while disabled", 32'h0, {29'h0, irq});
    wr(OFS_GEN_CTRL, 32'h1C00);
    pulse_all();
    chk("irq pending", 32'h7, {29'h0, irq});
    rdc(OFS_GEN_CTRL, 32'hFC00, RESP_OKAY, "status flags");
    wr(OFS_GEN_CTRL, 32'h1800);
    repeat (2) @(posedge clk);
    chk("irq after trigger disable", 32'h6, {29'h0, irq});
    rdc(OFS_GEN_CTRL, 32'hD800, RESP_OKAY, "flags after disable");
    wr(OFS_GEN_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq all cleared", 32'h0, {29'h0, irq});
  endtask

  task automatic t_prescale;
    for (int k = 0; k < 7; k++) begin
      wr(OFS_TIMEBASE_CTRL, 32'h0);
      wr(OFS_PRESCALE, 32'(k));
      wr(OFS_TIMEBASE_CTRL, 32'h8000);
      bnd(3, len);
      chk("boundary spacing", 32'(17 << k), 32'(len));
    end
    wr(OFS_TIMEBASE_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk("count while disabled", 32'h0, {16'h0, cnt});
    wr(OFS_PRESCALE, 32'h7);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    repeat (20) @(posedge clk);
    chk("count with reserved prescale", 32'h0, {16'h0, cnt});
    wr(OFS_TIMEBASE_CTRL, 32'h0);
    wr(OFS_PRESCALE, 32'h0);
  endtask

  task automatic t_dtm;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_GEN_CTRL, 32'(k << 6));
      repeat (3) @(posedge clk);
      chk("dead time mode", (k == 3) ? 32'(DTC_NONE) : 32'(k), {30'h0, dtm});
    end
    wr(OFS_GEN_CTRL, 32'h0);
  endtask

  task automatic t_itb;
    wr(OFS_GEN_CTRL, 32'h0004);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    repeat (3) @(posedge clk);
    chk("center without own base", 32'h0, {31'h0, ca});
    wr(OFS_TIMEBASE_CTRL, 32'h0);
    wr(OFS_GEN_CTRL, 32'h0200);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    bnd(3, len);
    chk("own base spacing", 32'd33, 32'(len));
    wr(OFS_TIMEBASE_CTRL, 32'h0);
    wr(OFS_GEN_CTRL, 32'h0204);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    repeat (3) @(posedge clk);
    chk("center with own base", 32'h1, {31'h0, ca});
    bnd(3, len);
    chk("center base spacing", 32'd64, 32'(len));
    wr(OFS_TIMEBASE_CTRL, 32'h0);
    wr(OFS_GEN_CTRL, 32'h0202);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    @(posedge clk);
    cev <= 1'b1;
    repeat (8) @(posedge clk);
    chk("count under external reset", 32'h0, {16'h0, cnt});
    chk("irq with enables off", 32'h0, {29'h0, irq});
    cev <= 1'b0;
    wr(OFS_TIMEBASE_CTRL, 32'h0);
  endtask

  task automatic t_duty;
    int ns;
    wr(OFS_SPECIAL_CMP, 32'h0008);
    wr(OFS_MASTER_PERIOD, 32'h0020);
    wr(OFS_GEN_CTRL, 32'h0001);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    bnd(3, len);
    @(posedge clk);
    chk("own primary duty", 32'd12, {16'h0, hon});
    chk("own secondary duty", 32'd14, {16'h0, lon});
    ns = nsev;
    bnd(1, len);
    chk("special events per cycle", 32'd1, 32'(nsev - ns));
    wr(OFS_TIMEBASE_CTRL, 32'h0);
    wr(OFS_GEN_CTRL, 32'h0100);
    wr(OFS_MASTER_DUTY, 32'h0010);
    wr(OFS_TIMEBASE_CTRL, 32'h8000);
    bnd(3, len);
    @(posedge clk);
    chk("master duty", 32'd16, {16'h0, hon});
    wr(OFS_MASTER_DUTY, 32'h0008);
    bnd(1, len);
    @(posedge clk);
    chk("duty held to boundary", 32'd16, {16'h0, hon});
    bnd(3, len);
    @(posedge clk);
    chk("coarse duty near edge", 32'd6, {16'h0, hon});
    wr(OFS_TIMEBASE_CTRL, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_bits();
    t_irq();
    t_prescale();
    t_dtm();
    t_itb();
    t_duty();
    end_of_test();
  end
endmodule
`default_nettype wire
